//--- hdl/adc_conv_ctl.sv
// converter control: AHB-Lite registers, start detect, 14-period sequence
// assumes the analog core delivers a stable result by the last period
`default_nettype none
`include "adc_ctl_params.svh"
module adc_conv_ctl
    import adc_ctl_pkg::*;
(
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic NRST_IN,
    // AHB-Lite slave
    input wire logic HSEL_IN,
    input wire logic [7:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HWDATA_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // analog side
    input wire logic LOW_VOLTAGE_RESET_IN,
    input wire logic [9:0] RESULT_IN,
    output analog_ctrl_s ANALOG_CTRL_OUT,
    output logic BANDGAP_POWER_OUT,
    output logic CONV_CLK_TICK_OUT,
    output logic SAMPLE_PHASE_OUT,
    output logic CONVERT_PHASE_OUT,
    // interrupt request to the processor
    output logic IRQ_OUT
);
    logic [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];
    logic [1:0] lvr_sync_r;
    logic [9:0] res_meta_r;
    logic [9:0] res_sync_r;

    // registers
    logic [7:0] ctl_first_r;
    logic [7:0] src_ref_clk_r;
    logic bandgap_enable_r;
    logic [1:0] int_en_r;
    logic req_flag_r;
    logic [9:0] result_r;
    logic busy_r;
    conv_state_e state_r;
    conv_state_e state_nxt;
    logic [3:0] per_r;
    logic [3:0] per_nxt;

    // bus pipeline
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // outputs
    analog_ctrl_s ctrl_r;
    logic bg_pwr_r;
    logic irq_r;
    logic tick;

    // reset release through two flops, assert asynchronously
    always_ff @(posedge MCLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // level and result inputs come from the analog domain
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvr_sync_r <= 2'h0;
            res_meta_r <= 10'h000;
            res_sync_r <= 10'h000;
        end
        else
        begin
            lvr_sync_r <= {lvr_sync_r[0], LOW_VOLTAGE_RESET_IN};
            res_meta_r <= RESULT_IN;
            res_sync_r <= res_meta_r;
        end
    end

    // address phase decode; any NONSEQ/SEQ transfer counts, HSIZE is not checked
    wire addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    wire rd_take = addr_ok && !HWRITE_IN;
    wire wr_take = addr_ok && HWRITE_IN;
    wire wr_ctl0 = wr_pend_r && (wr_addr_r == `OFS_CTL_FIRST);
    wire wr_ctl1 = wr_pend_r && (wr_addr_r == `OFS_SRC_REF_CLK);
    wire wr_bg = wr_pend_r && (wr_addr_r == `OFS_BANDGAP);
    wire wr_int = wr_pend_r && (wr_addr_r == `OFS_INT_CTL);
    wire [7:0] wd = HWDATA_IN[7:0];

    // start fires when a write drops a previously set start bit
    wire start_evt = wr_ctl0 && ctl_first_r[`BIT_START] && !wd[`BIT_START];
    wire power_on = ctl_first_r[`BIT_POWER];
    wire start_ok = start_evt && (state_r == ST_IDLE) && power_on;
    wire last_tick = tick && (state_r == ST_CONVERT) && (per_r == 4'(`CONVERT_PERIODS - 4'h1));
    wire done = last_tick && power_on;
    wire abort = !power_on && (state_r != ST_IDLE);
    wire [1:0] gain = {src_ref_clk_r[`BIT_GAIN_HI], ctl_first_r[`BIT_GAIN_LO]};
    wire align = ctl_first_r[`BIT_ALIGN];

    // split of the result into the two byte registers
    function automatic logic [15:0] split_result(input logic [9:0] d, input logic a);
        if (a)
            split_result = {6'h00, d[9:8], d[7:0]};
        else
            split_result = {d[9:2], d[1:0], 6'h00};
    endfunction : split_result

    wire [15:0] res_bytes = split_result(result_r, align);
    wire [7:0] ctl0_view = {1'b0, busy_r, ctl_first_r[5:0]};
    wire [7:0] int_view = {5'h00, req_flag_r, int_en_r};

    // read mux, sampled in the address phase so data comes from a flop
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (HADDR_IN)
            `OFS_CTL_FIRST: rdata_nxt[7:0] = ctl0_view;
            `OFS_SRC_REF_CLK: rdata_nxt[7:0] = src_ref_clk_r;
            `OFS_BANDGAP: rdata_nxt[`BIT_BANDGAP] = bandgap_enable_r;
            `OFS_RES_HIGH: rdata_nxt[7:0] = res_bytes[15:8];
            `OFS_RES_LOW: rdata_nxt[7:0] = res_bytes[7:0];
            `OFS_INT_CTL: rdata_nxt[7:0] = int_view;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // bus slave: zero wait states, always OKAY
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= wr_take;
            wr_addr_r <= wr_take ? HADDR_IN : wr_addr_r;
            rdata_r <= rd_take ? rdata_nxt : rdata_r;
        end
    end

    // software registers; busy is hardware owned and not writable
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_first_r <= `RST_CTL_FIRST;
            src_ref_clk_r <= `RST_SRC_REF_CLK;
            bandgap_enable_r <= 1'(`RST_BANDGAP >> `BIT_BANDGAP);
            int_en_r <= 2'(`RST_INT_CTL);
        end
        else
        begin
            if (wr_ctl0)
                ctl_first_r <= {wd[7], 1'b0, wd[5:0]};
            if (wr_ctl1)
                src_ref_clk_r <= wd;
            if (wr_bg)
                bandgap_enable_r <= wd[`BIT_BANDGAP];
            if (wr_int)
                int_en_r <= wd[1:0];
        end
    end

    // sequencer: 4 sample periods, then 10 convert periods
    always_comb
    begin
        state_nxt = state_r;
        per_nxt = per_r;
        unique case (state_r)
            ST_IDLE:
            begin
                per_nxt = 4'h0;
                if (start_ok)
                    state_nxt = ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
                if (tick)
                    per_nxt = 4'(per_r + 4'h1);
                if (tick && per_r == 4'(`SAMPLE_PERIODS - 4'h1))
                begin
                    state_nxt = ST_CONVERT;
                    per_nxt = 4'h0;
                end
            end
            ST_CONVERT:
            begin
                if (tick)
                    per_nxt = 4'(per_r + 4'h1);
                if (last_tick)
                    state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
                per_nxt = 4'h0;
            end
        endcase
        if (abort)
        begin
            state_nxt = ST_IDLE;
            per_nxt = 4'h0;
        end
    end

    // sequencer state, busy flag and result capture
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            per_r <= 4'h0;
            busy_r <= 1'b0;
            result_r <= 10'h000;
        end
        else
        begin
            state_r <= state_nxt;
            per_r <= per_nxt;
            busy_r <= (state_nxt != ST_IDLE);
            if (done)
                result_r <= res_sync_r;
        end
    end

    // request flag: completion sets it, software writes 0 to clear; set wins
    wire flag_clr = wr_int && !wd[`BIT_REQ_FLAG];
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
            req_flag_r <= 1'b0;
        else
            req_flag_r <= done || (req_flag_r && !flag_clr);
    end

    // registered outputs toward the analog core and the processor
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= '0;
            bg_pwr_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            ctrl_r.input_source_select <= src_ref_clk_r[7:6];
            ctrl_r.channel_select <= ctl_first_r[2:0];
            ctrl_r.reference_select <= src_ref_clk_r[4:3];
            ctrl_r.gain_select <= gain;
            ctrl_r.converter_power_enable <= power_on;
            bg_pwr_r <= bandgap_enable_r || lvr_sync_r[1];
            irq_r <= req_flag_r && int_en_r[`BIT_MASTER_IE] && int_en_r[`BIT_CONV_IE];
        end
    end

    // divider restarts with each accepted start so periods line up
    adc_clk_divider u_div (
        .clk(MCLK_IN),
        .rst_n(rst_n),
        .restart(start_ok),
        .sel(src_ref_clk_r[2:0]),
        .tick(tick)
    );

    assign HRDATA_OUT = rdata_r;
    assign HREADYOUT_OUT = rst_sync_r[1];
    assign HRESP_OUT = 1'b0;
    assign ANALOG_CTRL_OUT = ctrl_r;
    assign BANDGAP_POWER_OUT = bg_pwr_r;
    assign CONV_CLK_TICK_OUT = tick;
    assign SAMPLE_PHASE_OUT = state_r[1];
    assign CONVERT_PHASE_OUT = state_r[2];
    assign IRQ_OUT = irq_r;

    // helper: converter periods seen during the current conversion
    logic [4:0] ticks_r;
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
            ticks_r <= 5'h00;
        else if (start_ok)
            ticks_r <= 5'h00;
        else if (tick && busy_r)
            ticks_r <= 5'(ticks_r + 5'h01);
    end

    start_busy_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        start_ok |=> busy_r && state_r == ST_SAMPLE)
        else $error("busy not set after accepted start");
    level_start_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        !busy_r && !start_evt |=> !busy_r)
        else $error("conversion began without a start sequence");
    busy_ignore_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        start_evt && busy_r && !done && power_on |=> busy_r && ticks_r >= $past(ticks_r))
        else $error("start during conversion disturbed it");
    conv_length_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        done |-> ticks_r == 5'(`TOTAL_PERIODS - 5'h01))
        else $error("conversion not fourteen periods");
    flag_set_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        done |=> req_flag_r && !busy_r)
        else $error("request flag missing at completion");
    irq_gate_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        IRQ_OUT |-> $past(int_en_r) == 2'h3 && $past(req_flag_r))
        else $error("interrupt raised while disabled");
    bandgap_pwr_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        ##1 BANDGAP_POWER_OUT == ($past(bandgap_enable_r) || $past(lvr_sync_r[1])))
        else $error("bandgap power wrong");
    bg_unused_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        rd_take && HADDR_IN == `OFS_BANDGAP |=> (rdata_r & 32'hFFFF_FFF7) == 32'h0000_0000)
        else $error("unused bandgap bits read nonzero");
    src_ref_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        ##1 ctrl_r.input_source_select == $past(src_ref_clk_r[7:6])
        && ctrl_r.reference_select == $past(src_ref_clk_r[4:3]))
        else $error("source or reference routing wrong");
    gain_pair_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
        ##1 ctrl_r.gain_select == {$past(src_ref_clk_r[5]), $past(ctl_first_r[3])})
        else $error("gain bits misplaced");
endmodule : adc_conv_ctl
`default_nettype wire

//--- hdl/adc_ctl_params.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by adc_conv_ctl and the testbench; the package and the divider do not include it
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH
`define OFS_CTL_FIRST 8'h00
`define OFS_SRC_REF_CLK 8'h04
`define OFS_BANDGAP 8'h08
`define OFS_RES_HIGH 8'h0C
`define OFS_RES_LOW 8'h10
`define OFS_INT_CTL 8'h14
`define BIT_START 7
`define BIT_BUSY 6
`define BIT_POWER 5
`define BIT_ALIGN 4
`define BIT_GAIN_LO 3
`define BIT_GAIN_HI 5
`define BIT_BANDGAP 3
`define BIT_MASTER_IE 0
`define BIT_CONV_IE 1
`define BIT_REQ_FLAG 2
`define RST_CTL_FIRST 8'h00
`define RST_SRC_REF_CLK 8'h00
`define RST_BANDGAP 8'h00
`define RST_INT_CTL 8'h00
`define SAMPLE_PERIODS 4'h4
`define CONVERT_PERIODS 4'hA
`define TOTAL_PERIODS 5'h0E
`endif

//--- hdl/adc_ctl_pkg.sv
// types shared by the converter control block
// assumes the params header supplies all numeric constants
`default_nettype none
package adc_ctl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SAMPLE = 3'h2,
        ST_CONVERT = 3'h4
    } conv_state_e;
    // settings handed to the analog core and its multiplexers
    typedef struct packed {
        logic [1:0] input_source_select;
        logic [2:0] channel_select;
        logic [1:0] reference_select;
        logic [1:0] gain_select;
        logic converter_power_enable;
    } analog_ctrl_s;
endpackage : adc_ctl_pkg
`default_nettype wire

//--- hdl/adc_clk_divider.sv
// converter clock divider: one tick per 2**sel system clocks
// assumes sel is stable while a conversion runs
`default_nettype none
module adc_clk_divider
    import adc_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic tick_r;
    wire [6:0] lim = div_limit(sel);
    wire at_lim = (cnt_r == lim);

    // last count value for a divide of 2**s
    function automatic logic [6:0] div_limit(input logic [2:0] s);
        div_limit = 7'((8'h01 << s) - 8'h01);
    endfunction : div_limit

    // restart aligns the first period to the start of a conversion
    assign cnt_nxt = (restart || at_lim) ? 7'h00 : 7'(cnt_r + 7'h01);
    assign tick = tick_r;

    // counter and registered tick
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 7'h00;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= at_lim && !restart;
        end
    end

    div_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick_r && !$past(restart) |-> $past(cnt_r) == div_limit($past(sel)))
        else $error("converter tick off its divide period");
endmodule : adc_clk_divider
`default_nettype wire

//--- verif/analog_core_model.sv
// stand-in for the analog converter core at the block's far side
// assumes the bench sets value_in before each start sequence
`default_nettype none
module analog_core_model
    import adc_ctl_pkg::*;
#(
    parameter int SETTLE = 8
)
(
    input wire logic clk_in,
    input wire analog_ctrl_s ctrl_in,
    input wire logic active_in,
    input wire logic [9:0] value_in,
    output logic [9:0] result_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int settle_cnt = 0;
    logic [9:0] junk = 10'h155;
    // settling count since power-up; the pattern moves every cycle
    always @(posedge clk_in)
    begin
        settle_cnt <= ctrl_in.converter_power_enable ? settle_cnt + 1 : 0;
        junk <= ~junk;
    end
    // an unsettled or idle core never shows the held value
    assign result_out = (active_in && settle_cnt >= SETTLE) ? value_in : junk;
endmodule : analog_core_model
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the converter control block
// assumes one AHB-Lite master, the core model and a 20 MHz clock
`default_nettype none
`include "adc_ctl_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_ctl_pkg::*;
    logic mclk = 1'b0;
    logic nrst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic low_voltage_reset = 1'b0;
    logic [9:0] result;
    logic [9:0] value = 10'h000;
    analog_ctrl_s actrl;
    logic bg_pwr;
    logic samp;
    logic conv;
    logic irq;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 38;
    int samp_cnt = 0;
    int conv_cnt = 0;
    int tick_cnt = 0;
    logic tck;
    int ctl_m = 0;
    int src_m = 0;
    int bg_m = 0;
    int ie_m = 0;
    int flag_m = 0;
    int res_m = 0;
    logic [7:0] ctl;
    logic [7:0] d;
    logic [31:0] q;
    int n;

    always #25 mclk = ~mclk;

    adc_conv_ctl DUT (.MCLK_IN(mclk), .NRST_IN(nrst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HREADY_IN(hready),
        .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .LOW_VOLTAGE_RESET_IN(low_voltage_reset), .RESULT_IN(result), .ANALOG_CTRL_OUT(actrl),
        .BANDGAP_POWER_OUT(bg_pwr), .CONV_CLK_TICK_OUT(tck), .SAMPLE_PHASE_OUT(samp),
        .CONVERT_PHASE_OUT(conv), .IRQ_OUT(irq));

    analog_core_model core (.clk_in(mclk), .ctrl_in(actrl), .active_in(samp | conv),
        .value_in(value), .result_out(result));

    // phase lengths in system clocks, and converter ticks seen during the phases
    always @(posedge mclk)
    begin
        if (samp === 1'b1)
            samp_cnt++;
        if (conv === 1'b1)
            conv_cnt++;
        if (tck === 1'b1 && (samp === 1'b1 || conv === 1'b1))
            tick_cnt++;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_cnt(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp)
        begin
            bad_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    // one single transfer; address phase held until hready, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge mclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus

    // write, keeping the register mirror in step
    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        bus(1'b1, a, wd);
        case (a)
            `OFS_CTL_FIRST: ctl_m = wd & 8'h3F;
            `OFS_SRC_REF_CLK: src_m = wd;
            `OFS_BANDGAP: bg_m = wd & 8'h08;
            `OFS_INT_CTL:
            begin
                ie_m = wd & 8'h03;
                if (wd[2] == 1'b0)
                    flag_m = 0;
            end
            default: ;
        endcase
    endtask : wr

    // read and compare against the mirror; alignment applies at read time
    task automatic rd(input string what, input logic [7:0] a);
        int e;
        bus(1'b0, a, 8'h00);
        case (a)
            `OFS_CTL_FIRST: e = ctl_m;
            `OFS_SRC_REF_CLK: e = src_m;
            `OFS_BANDGAP: e = bg_m;
            `OFS_RES_HIGH: e = ctl_m[`BIT_ALIGN] ? res_m >> 8 : res_m >> 2;
            `OFS_RES_LOW: e = ctl_m[`BIT_ALIGN] ? res_m & 8'hFF : (res_m & 3) << 6;
            `OFS_INT_CTL: e = ie_m | (flag_m << 2);
            default: e = 0;
        endcase
        chk_val(what, e, q);
    endtask : rd

    initial
    begin
        repeat (5) @(posedge mclk);
        nrst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd("ctl reset", `OFS_CTL_FIRST);
        rd("src reset", `OFS_SRC_REF_CLK);
        rd("int reset", `OFS_INT_CTL);
        wr(8'h18, 8'hFF);
        rd("unmapped", 8'h18);
        // bandgap: loose bits read zero, power follows enable or lvr
        wr(`OFS_BANDGAP, 8'hFF);
        rd("bandgap", `OFS_BANDGAP);
        repeat (2) @(posedge mclk);
        chk_val("bg power", 1, bg_pwr);
        wr(`OFS_BANDGAP, 8'h00);
        low_voltage_reset <= 1'b1;
        repeat (4) @(posedge mclk);
        chk_val("bg power lvr", 1, bg_pwr);
        low_voltage_reset <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_val("bg power off", 0, bg_pwr);
        wr(`OFS_INT_CTL, 8'h03);
        // every source and reference code, divide codes kept in range
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            d[7:6] = i;
            d[4:3] = i; // no reference pin exists here, so internal references are safe
            d[2:0] = i + 4;
            ctl = $random(seed);
            ctl[7:5] = 3'h1;
            ctl[2] = (i != 0) | ctl[2];
            wr(`OFS_SRC_REF_CLK, d);
            wr(`OFS_CTL_FIRST, ctl);
            repeat (10) @(posedge mclk);
            rd("src", `OFS_SRC_REF_CLK);
            chk_val("analog", {d[7:6], ctl[2:0], d[4:3], d[5], ctl[3], 1'b1}, actrl);
            value = $random(seed);
            samp_cnt = 0;
            conv_cnt = 0;
            tick_cnt = 0;
            wr(`OFS_CTL_FIRST, ctl | 8'h80);
            repeat (4) @(posedge mclk);
            bus(1'b0, `OFS_CTL_FIRST, 8'h00);
            chk_val("busy on level", 0, q[6]);
            wr(`OFS_CTL_FIRST, ctl);
            wr(`OFS_CTL_FIRST, ctl | 8'h80);
            wr(`OFS_CTL_FIRST, ctl);
            bus(1'b0, `OFS_CTL_FIRST, 8'h00);
            chk_val("busy", 1, q[6]);
            n = 0;
            // slowest divide takes about 1800 clocks, each poll two
            while (q[6] === 1'b1 && n < 2000)
            begin
                bus(1'b0, `OFS_CTL_FIRST, 8'h00);
                n++;
            end
            flag_m = 1;
            res_m = value;
            rd("ctl done", `OFS_CTL_FIRST);
            // the accept edge stretches the first sample period by one system clock
            chk_cnt("sample clocks", (4 << d[2:0]) + 1, samp_cnt);
            chk_cnt("converter ticks", `TOTAL_PERIODS, tick_cnt);
            chk_cnt("convert clocks", 10 << d[2:0], conv_cnt);
            rd("result high", `OFS_RES_HIGH);
            rd("result low", `OFS_RES_LOW);
            rd("flag", `OFS_INT_CTL);
            chk_val("irq", 1, irq);
            wr(`OFS_INT_CTL, 8'h05);
            repeat (2) @(posedge mclk);
            chk_val("irq masked", 0, irq);
            wr(`OFS_INT_CTL, 8'h03);
            rd("flag clear", `OFS_INT_CTL);
        end
        // a start while powered down does nothing
        samp_cnt = 0;
        wr(`OFS_CTL_FIRST, 8'h00);
        wr(`OFS_CTL_FIRST, 8'h80);
        wr(`OFS_CTL_FIRST, 8'h00);
        repeat (40) @(posedge mclk);
        chk_cnt("no start", 0, samp_cnt);
        rd("ctl idle", `OFS_CTL_FIRST);
        chk_val("hresp", 0, hresp);
        tally_and_finish;
    end

    // cuts a hang short well beyond the longest expected run
    initial
    begin
        #(60000 * 50);
        bad_count++;
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
